//--- rtl/l3rx_pkg.sv
// Shared constants and types of the receive packet port
`default_nettype none
package l3rx_pkg;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned MOD_W       = 2;
   localparam int unsigned FIFO_DEPTH  = 16;
   localparam int unsigned RFCLK_MAX_MHZ = 104;
   localparam int unsigned SYS_CLK_MHZ = 250;
   localparam int unsigned RFCLK_PERIOD_NS = 1000 / RFCLK_MAX_MHZ;
   localparam int unsigned RFCLK_DIV = (SYS_CLK_MHZ + RFCLK_MAX_MHZ - 1) / RFCLK_MAX_MHZ;
   localparam logic [1:0]  MOD_ALL4    = 2'h0;
   localparam logic [1:0]  MOD_UPPER3  = 2'h1;
   localparam logic [1:0]  MOD_UPPER2  = 2'h2;
   localparam logic [1:0]  MOD_TOP1    = 2'h3;
   localparam logic        PAR_EVEN    = 1'h0;
   localparam logic        PAR_ODD     = 1'h1;
   localparam logic        WIDE_BUS    = 1'h0;
   localparam logic        NARROW_BUS  = 1'h1;
   // One word as it sits in the device buffer
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [MOD_W-1:0]  mod;
      logic              sop;
      logic              eop;
      logic              err;
   } l3rx_word_t;
   localparam int unsigned WORD_W = $bits(l3rx_word_t);
endpackage
`default_nettype wire

//--- rtl/l3rx_if.sv
// Receive link between device and link layer
`default_nettype none
interface l3rx_if;
   logic                            rd_en_n;
   logic [l3rx_pkg::DATA_W-1:0]     rdat;
   logic                            rval;
   logic                            rsop;
   logic                            reop;
   logic                            rerr;
   logic [l3rx_pkg::MOD_W-1:0]      rmod;
   logic                            rprty;
   modport dev  (input rd_en_n, output rdat, rval, rsop, reop, rerr, rmod, rprty);
   modport link (output rd_en_n, input rdat, rval, rsop, reop, rerr, rmod, rprty);
endinterface
`default_nettype wire

//--- rtl/l3rx_fifo.sv
// Parameterised valid/ready word FIFO
`default_nettype none
module l3rx_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic             i_sys_clk,
   input  wire logic             i_arst_n,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("l3rx_fifo: DEPTH must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } l3rx_fptr_t;
   l3rx_fptr_t st_q;
   l3rx_fptr_t st_d;
   logic       push;
   logic       pop;
   assign o_in_ready  = (st_q.cnt != DEPTH[AW:0]);
   assign o_out_valid = (st_q.cnt != '0);
   assign o_out_data  = mem[st_q.rd];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;
   always_comb
   begin
      st_d = st_q;
      if (push) st_d.wr = st_q.wr + 1'b1;
      if (pop) st_d.rd = st_q.rd + 1'b1;
      st_d.cnt = st_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n) st_q <= '0;
      else st_q <= st_d;
   end
   // Storage needs no reset; emptiness is tracked by the count
   always_ff @(posedge i_sys_clk)
   begin
      if (push) mem[st_q.wr] <= i_in_data;
   end
endmodule // l3rx_fifo
`default_nettype wire

//--- rtl/l3rx_dev.sv
// Device end: buffers packet words and serves link-layer reads
`default_nettype none
module l3rx_dev
   import l3rx_pkg::*;
#(
   parameter int unsigned DEPTH = l3rx_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                    i_sys_clk,
   input  wire logic                    i_arst_n,
   // Configuration
   input  wire logic                    i_narrow,
   input  wire logic                    i_par_odd,
   // Packet source
   input  wire logic                    i_pkt_valid,
   input  wire l3rx_pkg::l3rx_word_t    i_pkt_word,
   output logic                         o_pkt_ready,
   input  wire logic                    i_abort,
   input  wire logic                    i_src_par_err,
   // Link
   l3rx_if.dev                          rx
);
   initial
   begin
      if (DEPTH != FIFO_DEPTH) $error("l3rx_dev: buffer depth is fixed at sixteen");
      if (DATA_W != 32 || MOD_W != 2) $error("l3rx_dev: lanes are fixed at four bytes");
      if (RFCLK_DIV * RFCLK_MAX_MHZ < SYS_CLK_MHZ) $error("l3rx_dev: link edge rate above its limit");
   end
   typedef struct packed {
      logic [$clog2(RFCLK_DIV+1)-1:0] div;
      logic                            en_n;
      logic                            in_pkt;
      logic                            ovf;
      logic                            o_ready;
      logic [DATA_W-1:0]               rdat;
      logic                            rval;
      logic                            rsop;
      logic                            reop;
      logic                            rerr;
      logic [MOD_W-1:0]                rmod;
      logic                            rprty;
   } l3rx_dev_st_t;
   l3rx_dev_st_t st_q;
   l3rx_dev_st_t st_d;
   l3rx_word_t   in_w;
   l3rx_word_t   out_w;
   logic         fifo_rdy;
   logic         out_vld;
   logic         pop;
   logic         tick;
   logic         src_bad;
   // Ingress check: missing markers, abort and source parity flag an error
   always_comb
   begin
      in_w = i_pkt_word;
      src_bad = i_abort || i_src_par_err || (i_pkt_word.sop && st_q.in_pkt)
                || (!i_pkt_word.sop && !st_q.in_pkt);
      if (src_bad || st_q.ovf)
      begin
         in_w.eop = 1'b1;
         in_w.err = 1'b1;
      end
      if (in_w.eop && in_w.err) in_w.mod = MOD_ALL4;
      if (!in_w.eop) in_w.mod = MOD_ALL4;
   end
   l3rx_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (DEPTH)
   ) u_buf (
      .i_sys_clk   (i_sys_clk),
      .i_arst_n    (i_arst_n),
      .i_in_valid  (i_pkt_valid),
      .i_in_data   (in_w),
      .o_in_ready  (fifo_rdy),
      .o_out_valid (out_vld),
      .o_out_data  (out_w),
      .i_out_ready (pop)
   );
   // Link edges come at no more than the allowed rate
   assign tick = (st_q.div == '0);
   // Word after an end marker waits for the next read, so valid dips once
   assign pop  = tick && !st_q.en_n && out_vld && !(st_q.rval && st_q.reop);
   always_comb
   begin
      st_d = st_q;
      st_d.o_ready = fifo_rdy;
      if (st_q.div == '0) st_d.div = ($clog2(RFCLK_DIV+1))'(RFCLK_DIV - 1);
      else st_d.div = st_q.div - 1'b1;
      // Overflow: a refused word is lost; poison what follows until end
      if (i_pkt_valid && !fifo_rdy) st_d.ovf = 1'b1;
      if (i_pkt_valid && fifo_rdy)
      begin
         st_d.in_pkt = !in_w.eop;
         if (in_w.eop) st_d.ovf = 1'b0;
      end
      if (tick)
      begin
         st_d.en_n = rx.rd_en_n;
         if (!st_q.en_n)
         begin
            st_d.rval = out_vld && !(st_q.rval && st_q.reop);
            if (out_vld && !(st_q.rval && st_q.reop))
            begin
               if (i_narrow == NARROW_BUS)
                  st_d.rdat = {{(DATA_W-8){1'b0}}, out_w.data[DATA_W-1 -: 8]};
               else
                  st_d.rdat = out_w.data;
               st_d.rsop  = out_w.sop;
               st_d.reop  = out_w.eop;
               st_d.rerr  = out_w.err && out_w.eop;
               st_d.rmod  = out_w.eop ? out_w.mod : MOD_ALL4;
               st_d.rprty = (^st_d.rdat) ^ (i_par_odd == PAR_ODD);
            end
         end
         // With enable high nothing moves
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_q      <= '0;
         st_q.en_n <= 1'b1;
      end
      else st_q <= st_d;
   end
   assign o_pkt_ready = st_q.o_ready;
   assign rx.rdat  = st_q.rdat;
   assign rx.rval  = st_q.rval;
   assign rx.rsop  = st_q.rsop;
   assign rx.reop  = st_q.reop;
   assign rx.rerr  = st_q.rerr;
   assign rx.rmod  = st_q.rmod;
   assign rx.rprty = st_q.rprty;
endmodule // l3rx_dev
`default_nettype wire

//--- rtl/l3rx_link.sv
// Link-layer end: paces reads and flags errored packet ends on o_drop
`default_nettype none
module l3rx_link
   import l3rx_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_sys_clk,
   input  wire logic                 i_arst_n,
   // User side
   input  wire logic                 i_accept,
   output logic                      o_valid,
   output logic [DATA_W-1:0]         o_data,
   output logic [MOD_W-1:0]          o_mod,
   output logic                      o_sop,
   output logic                      o_eop,
   output logic                      o_drop,
   // Link
   l3rx_if.link                      rx
);
   typedef struct packed {
      logic [$clog2(RFCLK_DIV+1)-1:0] div;
      logic              en_n;
      logic              pend;
      logic              fresh;
      logic              valid;
      logic [DATA_W-1:0] data;
      logic [MOD_W-1:0]  mod;
      logic              sop;
      logic              eop;
      logic              drop;
   } l3rx_link_st_t;
   l3rx_link_st_t st_q;
   l3rx_link_st_t st_d;
   always_comb
   begin
      st_d = st_q;
      st_d.en_n = !i_accept;
      st_d.valid = 1'b0;
      st_d.drop = 1'b0;
      // Divider mirrors the device's; both leave reset together, so their edges agree
      if (st_q.div == '0)
      begin
         st_d.div = ($clog2(RFCLK_DIV+1))'(RFCLK_DIV - 1);
         // A held word shows again without a read, so only answered reads are taken
         st_d.pend  = !st_q.en_n;
         st_d.fresh = st_q.pend;
         if (st_q.fresh && rx.rval)
         begin
            st_d.valid = 1'b1;
            st_d.data  = rx.rdat;
            st_d.mod   = rx.rmod;
            st_d.sop   = rx.rsop;
            st_d.eop   = rx.reop;
            st_d.drop  = rx.reop && rx.rerr;
         end
      end
      else st_d.div = st_q.div - 1'b1;
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         st_q      <= '0;
         st_q.en_n <= 1'b1;
      end
      else st_q <= st_d;
   end
   assign rx.rd_en_n = st_q.en_n;
   assign o_valid = st_q.valid;
   assign o_data  = st_q.data;
   assign o_mod   = st_q.mod;
   assign o_sop   = st_q.sop;
   assign o_eop   = st_q.eop;
   assign o_drop  = st_q.drop;
endmodule // l3rx_link
`default_nettype wire

//--- tb/l3rx_properties.sv
// Link checks between device and link ends
`default_nettype none
module l3rx_properties (
   // Clock and reset
   input wire logic                        i_sys_clk,
   input wire logic                        i_arst_n,
   // Link
   input wire logic                        rd_en_n,
   input wire logic [l3rx_pkg::DATA_W-1:0] rdat,
   input wire logic                        rval,
   input wire logic                        rsop,
   input wire logic                        reop,
   input wire logic                        rerr,
   input wire logic [l3rx_pkg::MOD_W-1:0]  rmod,
   input wire logic                        rprty
);
   import l3rx_pkg::*;
   logic [38:0] outs;
   logic [3:0]  idle_q;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   assign outs = {rdat, rmod, rval, rsop, reop, rerr, rprty};
   // Cycles since a read request, saturating
   always_ff @(posedge i_sys_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         idle_q <= 4'h0;
      else if (!rd_en_n)
         idle_q <= 4'h0;
      else if (idle_q != 4'hf)
         idle_q <= idle_q + 4'h1;
   end
   a_err_needs_eop: assert property (rval && rerr |-> reop) else $error("error flag without end");
   a_mod_zero_mid: assert property (rval && !reop |-> rmod == 2'h0) else $error("modulo not zero");
   a_err_mod_zero: assert property (rval && rerr |-> rmod == 2'h0) else $error("errored modulo");
   a_hold_no_read: assert property (rd_en_n [*6] |=> $stable(outs)) else $error("outputs moved unasked");
   a_change_needs_read: assert property (!$stable(outs) |-> idle_q < 4'h6) else $error("late update");
   a_tick_spacing: assert property (!$stable(outs) |=> $stable(outs) [*2]) else $error("rate too high");
   a_drop_after_end: assert property ($past(rval && reop) && rval |-> reop && $stable(rdat))
      else $error("valid stayed after end");
   a_reset_idle: assert property ($rose(i_arst_n) |-> !rval && rd_en_n) else $error("not idle");
endmodule // l3rx_properties
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench joining device and link ends
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_count++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import l3rx_pkg::*;
   logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_narrow = 1'b0, i_par_odd = 1'b0;
   logic i_pkt_valid = 1'b0, i_abort = 1'b0, i_src_par_err = 1'b0, i_accept = 1'b0;
   l3rx_word_t i_pkt_word = '0;
   logic o_pkt_ready, o_valid, o_sop, o_eop, o_drop;
   logic [DATA_W-1:0] o_data, last_dat, sent;
   logic [MOD_W-1:0] o_mod;
   logic [31:0] seed = 32'h000047e4;
   logic [7:0] seq = 8'h00;
   logic stall = 1'b1, mon_on = 1'b0, last_ok = 1'b0;
   int err_count = 0, num_checks = 0, drops = 0, bad_sent = 0, n_wait = 0;
   l3rx_word_t exp_q[$];
   l3rx_word_t exp_l[$];
   l3rx_if u_l3rx_if ();
   l3rx_dev #(.DEPTH(FIFO_DEPTH)) u_l3rx_dev (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_narrow(i_narrow),
      .i_par_odd(i_par_odd), .i_pkt_valid(i_pkt_valid), .i_pkt_word(i_pkt_word), .o_pkt_ready(o_pkt_ready),
      .i_abort(i_abort), .i_src_par_err(i_src_par_err), .rx(u_l3rx_if));
   l3rx_link u_l3rx_link (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_accept(i_accept), .o_valid(o_valid),
      .o_data(o_data), .o_mod(o_mod), .o_sop(o_sop), .o_eop(o_eop), .o_drop(o_drop), .rx(u_l3rx_if));
   l3rx_properties u_l3rx_properties (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .rd_en_n(u_l3rx_if.rd_en_n),
      .rdat(u_l3rx_if.rdat), .rval(u_l3rx_if.rval), .rsop(u_l3rx_if.rsop), .reop(u_l3rx_if.reop),
      .rerr(u_l3rx_if.rerr), .rmod(u_l3rx_if.rmod), .rprty(u_l3rx_if.rprty));
   always #2 i_sys_clk = ~i_sys_clk;
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic exp_prty(input logic [DATA_W-1:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction
   task automatic complete_run();
      if (err_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Random withdrawal of the read request
   always @(posedge i_sys_clk)
      i_accept <= !stall && ((xs() % 4) != 0);
   // Sequence byte keeps neighbouring words distinct, so a held word is not counted twice
   always @(negedge i_sys_clk)
   begin
      if (o_drop === 1'b1)
         drops++;
      if (mon_on && o_valid === 1'b1)
         check_link();
      if (mon_on && u_l3rx_if.rval === 1'b1 && !(last_ok && u_l3rx_if.rdat === last_dat))
         check_word();
      if (u_l3rx_if.rval === 1'b1)
      begin
         last_dat = u_l3rx_if.rdat;
         last_ok = 1'b1;
      end
   end
   task automatic check_word();
      l3rx_word_t e;
      if (exp_q.size() == 0)
      begin
         `CHK("extra word", 1'b0, 1'b1)
         return;
      end
      e = exp_q.pop_front();
      `CHK("rdat", e.data, u_l3rx_if.rdat)
      `CHK("rsop", e.sop, u_l3rx_if.rsop)
      `CHK("reop", e.eop, u_l3rx_if.reop)
      `CHK("rerr", e.err, u_l3rx_if.rerr)
      `CHK("rmod", e.mod, u_l3rx_if.rmod)
      `CHK("rprty", exp_prty(e.data, i_par_odd), u_l3rx_if.rprty)
   endtask
   task automatic check_link();
      l3rx_word_t e;
      if (exp_l.size() == 0)
      begin
         `CHK("extra link word", 1'b0, 1'b1)
         return;
      end
      e = exp_l.pop_front();
      `CHK("o_data", e.data, o_data)
      `CHK("o_mod", e.mod, o_mod)
      `CHK("o_sop", e.sop, o_sop)
      `CHK("o_eop", e.eop, o_eop)
      `CHK("o_drop", e.err, o_drop)
   endtask
   task automatic send_pkt(input int n, input logic bad);
      l3rx_word_t w;
      logic [31:0] r;
      int t;
      for (int i = 0; i < n; i++)
      begin
         seq = seq + 8'h01;
         r = xs();
         w.data = {r[31:8], seq};
         w.sop = (i == 0);
         w.eop = (i == n - 1);
         w.mod = w.eop ? r[1:0] : 2'h0;
         w.err = 1'b0;
         sent = w.data;
         t = 0;
         // Offered only while ready; a word offered on a full buffer is lost
         do
         begin
            @(posedge i_sys_clk);
            t++;
         end
         while (o_pkt_ready !== 1'b1 && t < 2000);
         if (t >= 2000)
         begin
            err_count++;
            complete_run();
         end
         i_pkt_valid <= 1'b1;
         i_pkt_word <= w;
         i_abort <= bad && w.eop && r[2];
         i_src_par_err <= bad && w.eop && !r[2];
         @(posedge i_sys_clk);
         i_pkt_valid <= 1'b0;
         i_abort <= 1'b0;
         i_src_par_err <= 1'b0;
         if (bad && w.eop)
         begin
            w.err = 1'b1;
            w.mod = 2'h0;
            bad_sent++;
         end
         if (mon_on)
         begin
            exp_q.push_back(w);
            exp_l.push_back(w);
         end
         // Gap so the next late ready view already counts this word
         @(posedge i_sys_clk);
      end
   endtask
   task automatic drain();
      int t;
      t = 0;
      while ((exp_q.size() != 0 || exp_l.size() != 0) && t < 5000)
      begin
         @(posedge i_sys_clk);
         t++;
      end
      if (t >= 5000)
      begin
         err_count++;
         complete_run();
      end
      repeat (20) @(posedge i_sys_clk);
   endtask
   initial
   begin
      repeat (16) @(posedge i_sys_clk);
      i_arst_n <= 1'b1;
      mon_on <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      send_pkt(FIFO_DEPTH, 1'b0);
      repeat (4) @(posedge i_sys_clk);
      `CHK("ready full", 1'b0, o_pkt_ready)
      stall <= 1'b0;
      drain();
      for (int p = 0; p < 40; p++)
      begin
         if (p == 20)
         begin
            drain();
            i_par_odd <= 1'b1;
         end
         send_pkt(1 + (xs() % 6), (p % 5) == 4);
      end
      drain();
      `CHK("drops", bad_sent, drops)
      mon_on <= 1'b0;
      i_narrow <= 1'b1;
      send_pkt(1, 1'b0);
      while (o_valid !== 1'b1 && n_wait < 200)
      begin
         @(negedge i_sys_clk);
         n_wait++;
      end
      if (n_wait >= 200)
         err_count++;
      `CHK("narrow lane", sent[31:24], o_data[7:0])
      `CHK("narrow upper", 24'h0, o_data[31:8])
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
